// *** arb_defs.svh ***
// constants of the backplane arbiter: field widths, gap thresholds, credits
`ifndef ARB_DEFS_SVH
`define ARB_DEFS_SVH

// ----------------------------------------------------------------------------
// sequence fields
// ----------------------------------------------------------------------------
`define ARB_PRIO_W 4
`define ARB_NUM_W 6
`define ARB_SEQ_W 10
`define ARB_SEQ_LAST 4'h9
`define PRIO_FAIR 4'h0
`define PRIO_CYCLE_START 4'hF
`define PRIO_URGENT_MIN 4'h1
`define PRIO_URGENT_MAX 4'hE

// ----------------------------------------------------------------------------
// gap thresholds, in arbitration clock ticks of idle bus
// ----------------------------------------------------------------------------
`define IDLE_CNT_W 6
`define ACK_GAP_DETECT 6'h04
`define ACK_GAP_DRIVE 6'h08
`define SUB_GAP_DETECT 6'h10
`define SUB_GAP_DRIVE 6'h14
`define RST_GAP_DETECT 6'h1C
`define RST_GAP_DRIVE 6'h20
`define IDLE_CNT_MAX 6'h3F

// ----------------------------------------------------------------------------
// urgent credit and bus reset signalling
// ----------------------------------------------------------------------------
`define URGENT_CREDIT_W 2
`define URGENT_CREDIT_LOAD 2'h3
`define BUS_RESET_DRIVE_TICKS 6'h20
`define BUS_RESET_DETECT_TICKS 6'h18

`endif

// *** arb_pkg.sv ***
// types shared by the backplane arbiter modules
package arb_pkg;

    // ------------------------------------------------------------------------
    // arbitration classes requested by the link
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        CLASS_FAIR = 2'b00,
        CLASS_URGENT = 2'b01,
        CLASS_IMMEDIATE = 2'b10,
        CLASS_CYCLE_START = 2'b11
    } arb_class_e;

    // ------------------------------------------------------------------------
    // arbiter states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_ARB = 2'b10,
        ST_RESET = 2'b11
    } arb_state_e;

endpackage

// *** arb_gap_timer.sv ***
// idle and busy run counters of the backplane bus, in arbitration ticks
`timescale 1ns/1ps
`default_nettype none
`include "arb_defs.svh"

module arb_gap_timer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic bus_busy_i,
    output logic [5:0] idle_cnt_o,
    output logic interval_start_o,
    output logic reset_seen_o
);

    logic [5:0] busy_cnt_reg;

    // ------------------------------------------------------------------------
    // idle run: cleared at once by any activity, counted on ticks
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            idle_cnt_o <= 6'h00;
        end else if (bus_busy_i) begin
            idle_cnt_o <= 6'h00;
        end else if (tick_i && idle_cnt_o != `IDLE_CNT_MAX) begin
            idle_cnt_o <= idle_cnt_o + 6'h01;
        end
    end

    // new fairness interval once the idle run reaches the arbitration reset gap drive threshold
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            interval_start_o <= 1'b0;
        end else begin
            interval_start_o <= tick_i && !bus_busy_i
                && idle_cnt_o == `RST_GAP_DRIVE - 6'h01; // [R10] [R23]
        end
    end

    // ------------------------------------------------------------------------
    // busy run: a long asserted stretch is a bus reset
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            busy_cnt_reg <= 6'h00;
        end else if (!bus_busy_i) begin
            busy_cnt_reg <= 6'h00;
        end else if (tick_i && busy_cnt_reg != `IDLE_CNT_MAX) begin
            busy_cnt_reg <= busy_cnt_reg + 6'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reset_seen_o <= 1'b0;
        end else begin
            reset_seen_o <= tick_i && bus_busy_i
                && busy_cnt_reg == `BUS_RESET_DETECT_TICKS - 6'h01; // [R18]
        end
    end

endmodule
`default_nettype wire

// *** arb_credit_tracker.sv ***
// fair-enable flag and urgent credit of one node
`timescale 1ns/1ps
`default_nettype none
`include "arb_defs.svh"

module arb_credit_tracker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic urgent_support_i,
    input wire logic interval_start_i,
    input wire logic fair_win_i,
    input wire logic pkt_done_i,
    input wire logic pkt_urgent_i,
    output logic fair_en_o,
    output logic [1:0] urgent_cnt_o
);

    // ------------------------------------------------------------------------
    // fair enable: set wins over a clear in the same cycle
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fair_en_o <= 1'b1;
        end else if (interval_start_i) begin
            fair_en_o <= 1'b1; // [R8] [R10]
        end else if (fair_win_i) begin
            fair_en_o <= 1'b0; // [R8] [R12]
        end
    end

    // ------------------------------------------------------------------------
    // urgent credit: reload on fair traffic, spend on urgent traffic
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            urgent_cnt_o <= 2'h0;
        end else if (!urgent_support_i) begin
            urgent_cnt_o <= 2'h0;
        end else if (interval_start_i) begin
            urgent_cnt_o <= `URGENT_CREDIT_LOAD; // [R10]
        end else if (pkt_done_i && !pkt_urgent_i) begin
            urgent_cnt_o <= `URGENT_CREDIT_LOAD; // [R13]
        end else if (pkt_done_i && urgent_cnt_o != 2'h0) begin
            urgent_cnt_o <= urgent_cnt_o - 2'h1; // [R14]
        end
    end

endmodule
`default_nettype wire

// *** backplane_fair_urgent_arbiter.sv ***
// arbitration and bus reset logic of a backplane serial bus physical layer
//
// Functional notes
// R1 - sequence is 4 priority bits then 6 arbitration number bits.
// R2 - arbitration number is the node's own unique 6-bit slot id.
// R3 - sequence goes out MSB first: priority, then slot id.
// R4 - priority zero only for fair, all ones only for cycle start.
// R5 - acknowledge sends no sequence; wait ack gap, then start with data prefix.
// R6 - link requests arbitration; after class gap the sequence shifts out bitwise.
// R7 - fair or urgent waiters back off when the bus turns busy first.
// R8 - fair enable set at interval start, cleared on a fair win.
// R9 - fair packet arbitrates after subaction gap only with fair enable set.
// R10 - idle beyond arbitration reset gap starts interval; enable set, credit three.
// R11 - urgent arbitrates at subaction gap only with credit; wins send urgent label.
// R12 - fair win sends unlabelled packet and clears fair enable.
// R13 - any unlabelled packet sent or received reloads urgent credit to three.
// R14 - any urgent packet sent or received decrements urgent credit.
// R15 - winner has greatest priority and slot id concatenation.
// R16 - power-up resets state to defaults without driving a bus reset.
// R17 - a bus reset request makes the device drive a bus reset.
// R18 - a bus reset seen on the bus is reported to the link.
// R19 - either request bit starts bus reset; both clear on own reset.
// R20 - live insertion alone never generates a bus reset.
// R21 - ack gap recognised after 4 idle ticks, drive not before 8.
// R22 - subaction gap recognised after 16 idle ticks, drive not before 20.
// R23 - arbitration reset gap recognised after 28, drive not before 32.
// R24 - seeing a higher bus bit than sent loses; retry next gap.
`timescale 1ns/1ps
`default_nettype none
`include "arb_defs.svh"

module backplane_fair_urgent_arbiter #(
    parameter int SLOT_ID_W = 6
) (
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    // arbitration clock pin
    input wire logic ARB_CLK_I,
    // backplane arbitration line, wired-or, driven only for a one
    input wire logic BUS_I,
    output logic BUS_O,
    output logic BUS_OE_N_O,
    // node configuration
    input wire logic [SLOT_ID_W-1:0] NODE_SLOT_ID_I,
    input wire logic URGENT_SUPPORT_I,
    // arbitration request from the link
    input wire logic ARB_REQ_I,
    input wire arb_pkg::arb_class_e ARB_CLASS_I,
    input wire logic [3:0] ARB_PRIORITY_I,
    output logic ARB_PENDING_O,
    output logic ARB_WON_O,
    output logic ARB_LOST_O,
    output logic URGENT_LABEL_O,
    output logic ACK_START_O,
    // packets sent or received, as reported by the link
    input wire logic PKT_DONE_I,
    input wire logic PKT_URGENT_I,
    // status of the fairness bookkeeping
    output logic FAIR_ENABLE_O,
    output logic [1:0] URGENT_CREDIT_O,
    // bus reset control and status
    input wire logic BUS_RESET_REQUEST_BIT_SET_I,
    input wire logic ALT_BUS_RESET_REQUEST_BIT_SET_I,
    output logic BUS_RESET_REQUEST_BIT_O,
    output logic ALT_BUS_RESET_REQUEST_BIT_O,
    output logic BUS_RESET_STATUS_O
);
    import arb_pkg::*;

    // ------------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------------
    if (SLOT_ID_W != `ARB_NUM_W) begin : g_bad_width
        $error("slot id width must equal the arbitration number width");
    end

    arb_state_e state_reg;
    arb_class_e class_reg;
    logic [1:0] arb_clk_sync_reg;
    logic arb_clk_last_reg;
    logic [1:0] bus_sync_reg;
    logic tick;
    logic bus_busy;
    logic [5:0] idle_cnt;
    logic interval_start;
    logic reset_seen;
    logic fair_en;
    logic [1:0] urgent_cnt;
    logic [3:0] prio_reg;
    logic [`ARB_SEQ_W-1:0] seq_reg;
    logic [3:0] bit_cnt_reg;
    logic [5:0] rst_cnt_reg;
    logic drive_reg;
    logic [5:0] gap_need;
    logic gap_ready;
    logic reset_wanted;
    logic won;
    logic lost;
    logic [3:0] prio_eff;

    // ------------------------------------------------------------------------
    // pin synchronisers and arbitration tick
    // ------------------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            arb_clk_sync_reg <= 2'b00;
            arb_clk_last_reg <= 1'b0;
        end else begin
            arb_clk_sync_reg <= {arb_clk_sync_reg[0], ARB_CLK_I};
            arb_clk_last_reg <= arb_clk_sync_reg[1];
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            bus_sync_reg <= 2'b00;
        end else begin
            bus_sync_reg <= {bus_sync_reg[0], BUS_I};
        end
    end

    assign tick = arb_clk_sync_reg[1] && !arb_clk_last_reg;
    assign bus_busy = bus_sync_reg[1] || drive_reg;

    // ------------------------------------------------------------------------
    // gap timing and fairness bookkeeping
    // ------------------------------------------------------------------------
    arb_gap_timer u_gap (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESET_N_I),
        .tick_i(tick),
        .bus_busy_i(bus_busy),
        .idle_cnt_o(idle_cnt),
        .interval_start_o(interval_start),
        .reset_seen_o(reset_seen)
    );

    arb_credit_tracker u_credit (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESET_N_I),
        .urgent_support_i(URGENT_SUPPORT_I),
        .interval_start_i(interval_start),
        .fair_win_i(won && class_reg == CLASS_FAIR),
        .pkt_done_i(PKT_DONE_I),
        .pkt_urgent_i(PKT_URGENT_I),
        .fair_en_o(fair_en),
        .urgent_cnt_o(urgent_cnt)
    );

    assign FAIR_ENABLE_O = fair_en;
    assign URGENT_CREDIT_O = urgent_cnt;

    // ------------------------------------------------------------------------
    // request capture
    // ------------------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            ARB_PENDING_O <= 1'b0;
            class_reg <= CLASS_FAIR;
            prio_reg <= `PRIO_FAIR;
        end else if (ARB_REQ_I && !ARB_PENDING_O) begin
            ARB_PENDING_O <= 1'b1; // [R6]
            class_reg <= ARB_CLASS_I;
            prio_reg <= ARB_PRIORITY_I;
        end else if (won || ACK_START_O || reset_seen) begin
            ARB_PENDING_O <= 1'b0;
        end
    end

    // reserved priority codes are kept to their own classes
    always_comb begin
        case (class_reg)
            CLASS_FAIR: prio_eff = `PRIO_FAIR; // [R4]
            CLASS_CYCLE_START: prio_eff = `PRIO_CYCLE_START; // [R4]
            CLASS_URGENT: begin
                if (prio_reg == `PRIO_FAIR) begin
                    prio_eff = `PRIO_URGENT_MIN; // [R4]
                end else if (prio_reg == `PRIO_CYCLE_START) begin
                    prio_eff = `PRIO_URGENT_MAX; // [R4]
                end else begin
                    prio_eff = prio_reg;
                end
            end
            default: prio_eff = `PRIO_FAIR;
        endcase
    end

    // ------------------------------------------------------------------------
    // gap needed by the pending class
    // ------------------------------------------------------------------------
    always_comb begin
        case (class_reg)
            CLASS_IMMEDIATE: gap_need = `ACK_GAP_DRIVE; // [R5] [R21]
            CLASS_FAIR: gap_need = fair_en ? `SUB_GAP_DRIVE : `RST_GAP_DRIVE; // [R9] [R22]
            CLASS_URGENT: gap_need = (urgent_cnt != 2'h0) ? `SUB_GAP_DRIVE
                : `RST_GAP_DRIVE; // [R11] [R23]
            CLASS_CYCLE_START: gap_need = `SUB_GAP_DRIVE;
            default: gap_need = `RST_GAP_DRIVE;
        endcase
    end

    // a busy bus clears the idle count, so waiters back off by themselves
    assign gap_ready = !bus_busy && idle_cnt >= gap_need; // [R7]

    // ------------------------------------------------------------------------
    // bus reset request bits: a set in the clearing cycle is kept
    // ------------------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            BUS_RESET_REQUEST_BIT_O <= 1'b0; // [R16]
        end else if (BUS_RESET_REQUEST_BIT_SET_I) begin
            BUS_RESET_REQUEST_BIT_O <= 1'b1; // [R19]
        end else if (reset_seen && state_reg == ST_RESET) begin
            BUS_RESET_REQUEST_BIT_O <= 1'b0; // [R19]
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            ALT_BUS_RESET_REQUEST_BIT_O <= 1'b0; // [R16]
        end else if (ALT_BUS_RESET_REQUEST_BIT_SET_I) begin
            ALT_BUS_RESET_REQUEST_BIT_O <= 1'b1; // [R19]
        end else if (reset_seen && state_reg == ST_RESET) begin
            ALT_BUS_RESET_REQUEST_BIT_O <= 1'b0; // [R19]
        end
    end

    assign reset_wanted = BUS_RESET_REQUEST_BIT_O || ALT_BUS_RESET_REQUEST_BIT_O;

    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            BUS_RESET_STATUS_O <= 1'b0;
        end else begin
            BUS_RESET_STATUS_O <= reset_seen; // [R18]
        end
    end

    // ------------------------------------------------------------------------
    // contest outcome on each tick while arbitrating
    // ------------------------------------------------------------------------
    assign lost = state_reg == ST_ARB && tick && !seq_reg[`ARB_SEQ_W-1]
        && bus_sync_reg[1]; // [R15] [R24]
    assign won = state_reg == ST_ARB && tick && !lost
        && bit_cnt_reg == `ARB_SEQ_LAST; // [R15]

    // ------------------------------------------------------------------------
    // arbiter sequencing; power-up leaves the bus released
    // ------------------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            state_reg <= ST_IDLE; // [R16] [R20]
            seq_reg <= '0;
            bit_cnt_reg <= 4'h0;
            rst_cnt_reg <= 6'h00;
            drive_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    drive_reg <= 1'b0;
                    if (reset_wanted) begin
                        state_reg <= ST_RESET; // [R17]
                        rst_cnt_reg <= 6'h00;
                        drive_reg <= 1'b1;
                    end else if (ARB_PENDING_O && !ACK_START_O && !won) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (reset_wanted) begin
                        state_reg <= ST_IDLE;
                    end else if (gap_ready && class_reg == CLASS_IMMEDIATE) begin
                        state_reg <= ST_IDLE; // [R5]
                    end else if (gap_ready) begin
                        seq_reg <= {prio_eff, NODE_SLOT_ID_I}; // [R1] [R2]
                        bit_cnt_reg <= 4'h0;
                        drive_reg <= 1'b1; // [R6]
                        state_reg <= ST_ARB;
                    end
                end
                ST_ARB: begin
                    if (lost || won) begin
                        drive_reg <= 1'b0; // [R24]
                        state_reg <= lost ? ST_WAIT : ST_IDLE;
                    end else if (tick) begin
                        seq_reg <= {seq_reg[`ARB_SEQ_W-2:0], 1'b0}; // [R3]
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                end
                ST_RESET: begin
                    if (tick) begin
                        rst_cnt_reg <= rst_cnt_reg + 6'h01;
                    end
                    if (tick && rst_cnt_reg == `BUS_RESET_DRIVE_TICKS - 6'h01) begin
                        drive_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    drive_reg <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // line driver: only ones are driven, zeros leave the line released
    // ------------------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            BUS_O <= 1'b0;
            BUS_OE_N_O <= 1'b1; // [R16] [R20]
        end else begin
            BUS_O <= 1'b1;
            BUS_OE_N_O <= !(drive_reg && (state_reg == ST_RESET
                || (state_reg == ST_ARB && seq_reg[`ARB_SEQ_W-1]))); // [R3] [R17]
        end
    end

    // ------------------------------------------------------------------------
    // link indications
    // ------------------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            ARB_WON_O <= 1'b0;
            ARB_LOST_O <= 1'b0;
            ACK_START_O <= 1'b0;
            URGENT_LABEL_O <= 1'b0;
        end else begin
            ARB_WON_O <= won;
            ARB_LOST_O <= lost; // [R24]
            ACK_START_O <= state_reg == ST_WAIT && !reset_wanted && gap_ready
                && class_reg == CLASS_IMMEDIATE && !ACK_START_O; // [R5]
            if (won) begin
                URGENT_LABEL_O <= class_reg == CLASS_URGENT; // [R11] [R12]
            end
        end
    end

endmodule
`default_nettype wire

// *** arb_ports_chk_asserts.sv ***
// port checker of the backplane arbiter
`timescale 1ns/1ps
`default_nettype none
module arb_ports_chk (
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic BUS_O,
    input wire logic BUS_OE_N_O,
    input wire logic ARB_PENDING_O,
    input wire logic ARB_WON_O,
    input wire logic ARB_LOST_O,
    input wire logic ACK_START_O,
    input wire logic PKT_DONE_I,
    input wire logic PKT_URGENT_I,
    input wire logic URGENT_SUPPORT_I,
    input wire logic [1:0] URGENT_CREDIT_O,
    input wire logic BUS_RESET_REQUEST_BIT_SET_I,
    input wire logic ALT_BUS_RESET_REQUEST_BIT_SET_I,
    input wire logic BUS_RESET_REQUEST_BIT_O,
    input wire logic ALT_BUS_RESET_REQUEST_BIT_O,
    input wire logic BUS_RESET_STATUS_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // ----
    // properties
    // ----
    reset_quiet_a: assert property (disable iff (1'b0) !RESET_N_I |=> BUS_OE_N_O)
        else $error("line driven after reset");
    drive_one_a: assert property (!BUS_OE_N_O |-> BUS_O)
        else $error("line driven low");
    won_pulse_a: assert property (ARB_WON_O |-> !ARB_PENDING_O ##1 !ARB_WON_O)
        else $error("win pulse wrong");
    lost_retry_a: assert property (ARB_LOST_O |=> ARB_PENDING_O && !ARB_LOST_O)
        else $error("lost node gave up");
    ack_quiet_a: assert property (ACK_START_O |-> BUS_OE_N_O)
        else $error("sequence sent for ack");
    credit_load_a: assert property (PKT_DONE_I && !PKT_URGENT_I && URGENT_SUPPORT_I
        |=> URGENT_CREDIT_O == 2'h3)
        else $error("credit not reloaded");
    credit_dec_a: assert property (PKT_DONE_I && PKT_URGENT_I && URGENT_CREDIT_O != 2'h0
        |=> URGENT_CREDIT_O == $past(URGENT_CREDIT_O) - 2'h1)
        else $error("credit not decremented");
    no_credit_a: assert property (!URGENT_SUPPORT_I && !$past(URGENT_SUPPORT_I)
        |-> URGENT_CREDIT_O == 2'h0)
        else $error("credit without support");
    bit_set_a: assert property (BUS_RESET_REQUEST_BIT_SET_I |=> BUS_RESET_REQUEST_BIT_O)
        else $error("request bit not set");
    alt_set_a: assert property (ALT_BUS_RESET_REQUEST_BIT_SET_I
        |=> ALT_BUS_RESET_REQUEST_BIT_O)
        else $error("alt request bit not set");
    won_c: cover property (ARB_WON_O);
    lost_c: cover property (ARB_LOST_O);
    ack_c: cover property (ACK_START_O);
    status_c: cover property (BUS_RESET_STATUS_O);
endmodule
bind backplane_fair_urgent_arbiter arb_ports_chk chk_i (.*);
`default_nettype wire

// *** arb_peer.sv ***
// peer node on the wired-or arbitration line
`timescale 1ns/1ps
`default_nettype none
module arb_peer (
    input wire logic arb_clk_i,
    input wire logic line_i,
    input wire logic go_i,
    input wire logic hold_i,
    input wire logic [9:0] seq_i,
    output logic drive_o
);
    logic [5:0] idle_reg = 6'h00;
    logic [9:0] sh_reg = 10'h000;
    logic [3:0] left_reg = 4'h0;
    always @(posedge arb_clk_i) begin
        idle_reg <= line_i ? 6'h00 : (idle_reg == 6'h3F ? idle_reg : idle_reg + 6'h01);
        if (left_reg != 4'h0) begin
            sh_reg <= {sh_reg[8:0], 1'b0};
            left_reg <= left_reg - 4'h1;
        end else if (go_i && idle_reg == 6'h15) begin
            sh_reg <= seq_i;
            left_reg <= 4'hA;
        end
    end
    // only ones are driven; hold stands for busy traffic or a bus reset
    assign drive_o = hold_i | (left_reg != 4'h0 && sh_reg[9]);
endmodule
`default_nettype wire

// *** test_backplane_fair_urgent_arbiter.sv ***
// self-checking bench of the backplane arbiter
`timescale 1ns/1ps
`default_nettype none
module test_backplane_fair_urgent_arbiter;
    import arb_pkg::*;
    logic REF_CLK_I = 0, RESET_N_I = 0, ARB_CLK_I = 0, BUS_I, BUS_O, BUS_OE_N_O;
    logic URGENT_SUPPORT_I = 1, ARB_REQ_I = 0, PKT_DONE_I = 0, PKT_URGENT_I = 0;
    logic BUS_RESET_REQUEST_BIT_SET_I = 0, ALT_BUS_RESET_REQUEST_BIT_SET_I = 0;
    logic ARB_PENDING_O, ARB_WON_O, ARB_LOST_O, URGENT_LABEL_O, ACK_START_O;
    logic FAIR_ENABLE_O, BUS_RESET_REQUEST_BIT_O, ALT_BUS_RESET_REQUEST_BIT_O;
    logic BUS_RESET_STATUS_O, go = 0, hold = 0, drv;
    logic [5:0] NODE_SLOT_ID_I = 6'h2D;
    logic [3:0] ARB_PRIORITY_I = 4'h0;
    logic [1:0] URGENT_CREDIT_O;
    logic [9:0] seq = 10'h000;
    logic [2:0] ev;
    arb_class_e ARB_CLASS_I = CLASS_FAIR;
    int fails = 0, tests_run = 0, oe_cnt = 0, n;
    time t0;
    backplane_fair_urgent_arbiter dut (.*);
    arb_peer peer (.arb_clk_i(ARB_CLK_I), .line_i(BUS_I), .go_i(go), .hold_i(hold),
        .seq_i(10'h3BF), .drive_o(drv));
    assign BUS_I = drv | (BUS_OE_N_O === 1'b0 && BUS_O === 1'b1);
    initial forever #2.5 REF_CLK_I = !REF_CLK_I;
    initial #1 forever #62.5 ARB_CLK_I = !ARB_CLK_I;
    // ----
    // line observers: serial bits and driven cycles
    // ----
    always @(negedge ARB_CLK_I) if (ARB_PENDING_O === 1'b1) seq = {seq[8:0], BUS_OE_N_O === 1'b0};
    always @(negedge REF_CLK_I) if (BUS_OE_N_O === 1'b0) oe_cnt++;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic arb(input arb_class_e c, input logic [3:0] p);
        @(negedge REF_CLK_I);
        ARB_CLASS_I = c;
        ARB_PRIORITY_I = p;
        ARB_REQ_I = 1;
        t0 = $time;
        @(negedge REF_CLK_I);
        ARB_REQ_I = 0;
    endtask
    task automatic await;
        ev = 3'h0;
        for (int i = 0; i < 9000 && ev == 3'h0; i++) begin
            @(negedge REF_CLK_I);
            ev = {ARB_WON_O, ARB_LOST_O, ACK_START_O | BUS_RESET_STATUS_O};
        end
    endtask
    task automatic pkt(input logic u);
        @(negedge REF_CLK_I);
        PKT_DONE_I = 1;
        PKT_URGENT_I = u;
        @(negedge REF_CLK_I);
        PKT_DONE_I = 0;
        @(negedge REF_CLK_I);
    endtask
    initial begin
        #400000;
        fails++;
        close_out();
    end
    initial begin
        repeat (5) @(negedge REF_CLK_I);
        RESET_N_I = 1;
        chk({BUS_OE_N_O, ARB_PENDING_O, FAIR_ENABLE_O, URGENT_CREDIT_O,
            BUS_RESET_REQUEST_BIT_O, ALT_BUS_RESET_REQUEST_BIT_O}, 10'h050);
        repeat (34) @(posedge ARB_CLK_I);
        @(negedge REF_CLK_I);
        chk(URGENT_CREDIT_O, 10'h3);
        arb(CLASS_URGENT, 4'h9);
        await();
        chk(ev, 10'h4);
        chk(seq, 10'h26D);
        pkt(1'b1);
        chk({URGENT_LABEL_O, URGENT_CREDIT_O}, 10'h6);
        pkt(1'b0);
        chk(URGENT_CREDIT_O, 10'h3);
        // busy line before the gap: no drive, win only once it is idle
        arb(CLASS_URGENT, 4'h5);
        hold = 1;
        n = oe_cnt;
        repeat (20) @(posedge ARB_CLK_I);
        chk(oe_cnt == n, 10'h1);
        hold = 0;
        t0 = $time;
        await();
        chk({ev, $time - t0 > 3600 && $time - t0 < 3900}, 10'h9);
        // peer with higher priority contests, then the retry wins
        go = 1;
        arb(CLASS_URGENT, 4'h0);
        await();
        chk(ev, 10'h2);
        go = 0;
        await();
        chk({ev, seq}, {3'h4, 10'h06D});
        arb(CLASS_CYCLE_START, 4'h0);
        await();
        chk(seq, 10'h3ED);
        arb(CLASS_FAIR, 4'h7);
        await();
        chk(seq, 10'h02D);
        repeat (2) @(negedge REF_CLK_I);
        chk({URGENT_LABEL_O, FAIR_ENABLE_O}, 10'h0);
        arb(CLASS_FAIR, 4'h0);
        await();
        chk({ev, $time - t0 >= 5100}, 10'h9);
        arb(CLASS_IMMEDIATE, 4'h0);
        n = oe_cnt;
        await();
        chk({ev, oe_cnt == n}, 10'h3);
        chk($time - t0 >= 900 && $time - t0 < 1800, 10'h1);
        // own bus reset through both request bits
        @(negedge REF_CLK_I);
        BUS_RESET_REQUEST_BIT_SET_I = 1;
        ALT_BUS_RESET_REQUEST_BIT_SET_I = 1;
        n = oe_cnt;
        @(negedge REF_CLK_I);
        BUS_RESET_REQUEST_BIT_SET_I = 0;
        ALT_BUS_RESET_REQUEST_BIT_SET_I = 0;
        chk({BUS_RESET_REQUEST_BIT_O, ALT_BUS_RESET_REQUEST_BIT_O}, 10'h3);
        await();
        chk({ev, oe_cnt - n > 500}, 10'h3);
        @(negedge REF_CLK_I);
        chk({BUS_RESET_REQUEST_BIT_O, ALT_BUS_RESET_REQUEST_BIT_O}, 10'h0);
        // bus reset made by the peer
        repeat (20) @(posedge ARB_CLK_I);
        hold = 1;
        await();
        hold = 0;
        chk(ev, 10'h1);
        URGENT_SUPPORT_I = 0;
        repeat (3) @(negedge REF_CLK_I);
        chk(URGENT_CREDIT_O, 10'h0);
        close_out();
    end
endmodule
`default_nettype wire
